// File: verilog/ufs_pkg.sv
// Package of register map, field layout and constants for the USB flag and status block
`default_nettype none
package ufs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FLAG_VECTOR = 8'h1c;
  localparam logic [7:0] OFS_FLAG_HOLD_SELECT = 8'h20;
  localparam logic [7:0] OFS_FLAG_ROUTE_MASKS = 8'h24;
  localparam logic [7:0] OFS_FRAME_NUMBER = 8'h28;
  localparam logic [7:0] OFS_LAST_PACKET_ID = 8'h2c;
  localparam logic [7:0] OFS_LAST_ENDPOINT = 8'h30;
  localparam logic [7:0] OFS_ENDPOINT_MARKING = 8'h34;
  localparam logic [7:0] OFS_SUSPEND_SIGNAL_WORD = 8'h38;
  localparam logic [7:0] OFS_PHY_LINE_CONTROL = 8'h3c;
  // Widths
  localparam int FLAG_W = 7;
  localparam int FRAME_W = 11;
  localparam int NIB_W = 4;
  localparam int EP_COUNT = 16;
  localparam int FILT_CNT_W = 16;
  // Flag bit positions
  localparam int FLG_TOKEN = 6;
  localparam int FLG_SE0 = 5;
  localparam int FLG_K = 4;
  localparam int FLG_J = 3;
  localparam int FLG_CRC = 2;
  localparam int FLG_RXACTIVE = 1;
  localparam int FLG_RXERROR = 0;
  // Flags driven by one-cycle events rather than levels
  localparam logic [6:0] FLAG_EVENT_MASK = 7'h44;
  // Route mask field positions
  localparam int MSK_FIRST_LO = 0;
  localparam int MSK_SECOND_LO = 8;
  localparam int MSK_THIRD_LO = 16;
  // Endpoint register fields
  localparam int EP_VALID_BIT = 4;
  localparam logic [4:0] EP_MARK_OR = 5'h10;
  // Power signalling fields
  localparam int PWR_VALID_BIT = 8;
  // PHY control fields
  localparam int PHY_PULLDOWN_DIS = 18;
  localparam int PHY_CAUSE_SE0 = 13;
  localparam int PHY_CAUSE_K = 12;
  localparam int PHY_FILT_LO = 8;
  localparam int PHY_AUTO_RESUME = 7;
  localparam int PHY_CONF_LO = 4;
  localparam int PHY_CONF_W = 3;
  // Reset values
  localparam logic [31:0] REG_RESET = 32'h0;
  // UTMI linestate codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
endpackage : ufs_pkg
`default_nettype wire

// File: verilog/ufs_line_if.sv
// Interface between register logic and the linestate filter
`timescale 1ns/100ps
`default_nettype none
interface ufs_line_if;
  logic [1:0] lineRaw; // Unfiltered linestate
  logic [3:0] filterLog2; // Log-2 filter length
  logic autoResumeEn; // Automatic resume enable
  logic suspended; // Link is in suspend
  logic [1:0] lineFilt; // Filtered linestate
  logic resumeSe0; // Auto-resume seen, SE0 cause
  logic resumeK; // Auto-resume seen, K cause
  // Register side
  modport ctrl (output lineRaw, output filterLog2, output autoResumeEn, output suspended,
                input lineFilt, input resumeSe0, input resumeK);
  // Filter side
  modport filt (input lineRaw, input filterLog2, input autoResumeEn, input suspended,
                output lineFilt, output resumeSe0, output resumeK);
endinterface : ufs_line_if
`default_nettype wire

// File: verilog/ufs_line_filter.sv
// Linestate filter and auto-resume cause detector
`timescale 1ns/100ps
`default_nettype none
module ufs_line_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to register logic
  ufs_line_if.filt line
);
  import ufs_pkg::*;

  logic [1:0] candReg; // Candidate new linestate
  logic [1:0] filtReg; // Accepted linestate
  logic [FILT_CNT_W-1:0] cntReg; // Stable cycles of candidate
  logic [FILT_CNT_W-1:0] limit; // Filter length minus one
  logic seReg; // SE0 cause pulse
  logic kReg; // K cause pulse

  // Required stable length is two to the power of the setting
  assign limit = FILT_CNT_W'((32'h1 << line.filterLog2) - 32'h1);

  // Candidate tracking and delayed acceptance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      candReg <= LS_SE0;
      filtReg <= LS_SE0;
      cntReg <= '0;
    end else if (line.lineRaw != candReg) begin
      // New level: restart the count
      candReg <= line.lineRaw;
      cntReg <= '0;
    end else if (candReg != filtReg) begin
      if (cntReg >= limit) begin
        filtReg <= candReg;
        cntReg <= '0;
      end else begin
        cntReg <= cntReg + FILT_CNT_W'(1);
      end
    end
  end

  // Auto-resume: a change away from idle while suspended marks its cause
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seReg <= 1'b0;
      kReg <= 1'b0;
    end else begin
      seReg <= 1'b0;
      kReg <= 1'b0;
      if (line.autoResumeEn && line.suspended && candReg != filtReg && cntReg >= limit) begin
        seReg <= (candReg == LS_SE0);
        kReg <= (candReg == LS_K);
      end
    end
  end

  assign line.lineFilt = filtReg;
  assign line.resumeSe0 = seReg;
  assign line.resumeK = kReg;
endmodule : ufs_line_filter
`default_nettype wire

// File: verilog/ufs_flag_status.sv
// Top of the USB flag, status and PHY line control block
`timescale 1ns/100ps
`default_nettype none
module ufs_flag_status (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port, 32-bit word accesses
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regRdValid,
  // Transceiver and decoder inputs
  input wire logic [1:0] lineState,
  input wire logic rxActive,
  input wire logic rxError,
  input wire logic tokenOk,
  input wire logic crcFail,
  input wire logic packetStart,
  input wire logic pidValid,
  input wire logic [ufs_pkg::NIB_W-1:0] pidIn,
  input wire logic epValid,
  input wire logic [ufs_pkg::NIB_W-1:0] epIn,
  input wire logic sofValid,
  input wire logic [ufs_pkg::FRAME_W-1:0] sofFrame,
  input wire logic suspended,
  // Flag outputs
  output logic flagOutFirst,
  output logic flagOutSecond,
  output logic flagOutThird,
  // Receive endpoint delivery
  output logic [4:0] rxEndpoint,
  output logic rxEndpointStrobe,
  // PHY line controls
  output logic pulldownDisable,
  output logic [ufs_pkg::PHY_CONF_W-1:0] phyConfigPins,
  output logic [1:0] lineStateFilt,
  output logic autoResume,
  output logic resumeDetected,
  // Power signalling
  output logic powerSignalValid,
  output logic [7:0] powerSignalData
);
  import ufs_pkg::*;

  // Register state
  logic [FLAG_W-1:0] engineFlagVector_reg; // Monitored flags
  logic [FLAG_W-1:0] engineFlagVector_next; // Next flag value
  logic [FLAG_W-1:0] flagHoldSelect_reg; // Per-flag hold select
  logic [31:0] flagRouteMasks_reg; // Three route masks
  logic [FRAME_W-1:0] frameNumber_reg; // Frame number
  logic [NIB_W-1:0] lastPacketId_reg; // Last PID
  logic [NIB_W-1:0] lastEndpoint_reg; // Last endpoint
  logic lastEndpointValid_reg; // Endpoint value valid
  logic [EP_COUNT-1:0] endpointMarking_reg; // Marked endpoints
  logic [8:0] suspendSignalWord_reg; // Power signalling word
  logic pulldownDisable_reg; // Pulldown disable
  logic causeSe0_reg; // Resume was reset
  logic causeK_reg; // Resume was K
  logic [3:0] filterLog2_reg; // Filter length setting
  logic autoResume_reg; // Auto-resume select
  logic [PHY_CONF_W-1:0] phyConf_reg; // Config pin levels

  // Decoded accesses
  logic wrFlags; // Write to flag vector
  logic wrHold; // Write to hold select
  logic wrMasks; // Write to route masks
  logic wrFrame; // Write to frame number
  logic wrMark; // Write to endpoint marking
  logic wrPower; // Write to power word
  logic wrPhy; // Write to PHY control
  logic [FLAG_W-1:0] flagSrc; // Current flag sources
  logic [FLAG_W-1:0] flagClear; // Software clear per flag
  logic [31:0] rdMux; // Read data before register
  logic [31:0] phyWord; // Assembled PHY control

  ufs_line_if lineBus ();

  // Linestate filter and resume detection
  ufs_line_filter uFilter (
    .clk(clk),
    .rst_n(rst_n),
    .line(lineBus.filt)
  );

  assign lineBus.lineRaw = lineState;
  assign lineBus.filterLog2 = filterLog2_reg;
  assign lineBus.autoResumeEn = autoResume_reg;
  assign lineBus.suspended = suspended;

  // Address decode of writes
  assign wrFlags = regWrEn && (regAddr == OFS_FLAG_VECTOR);
  assign wrHold = regWrEn && (regAddr == OFS_FLAG_HOLD_SELECT);
  assign wrMasks = regWrEn && (regAddr == OFS_FLAG_ROUTE_MASKS);
  assign wrFrame = regWrEn && (regAddr == OFS_FRAME_NUMBER);
  assign wrMark = regWrEn && (regAddr == OFS_ENDPOINT_MARKING);
  assign wrPower = regWrEn && (regAddr == OFS_SUSPEND_SIGNAL_WORD);
  assign wrPhy = regWrEn && (regAddr == OFS_PHY_LINE_CONTROL);

  // Flag sources, in documented bit order
  always_comb begin
    flagSrc = '0;
    flagSrc[FLG_TOKEN] = tokenOk;
    flagSrc[FLG_SE0] = (lineBus.lineFilt == LS_SE0);
    flagSrc[FLG_K] = (lineBus.lineFilt == LS_K);
    flagSrc[FLG_J] = (lineBus.lineFilt == LS_J);
    flagSrc[FLG_CRC] = crcFail;
    flagSrc[FLG_RXACTIVE] = rxActive;
    flagSrc[FLG_RXERROR] = rxError;
  end

  // Writing a one clears a held flag
  assign flagClear = wrFlags ? regWrData[FLAG_W-1:0] : '0;

  // Per-flag next value
  generate
    for (genvar i = 0; i < FLAG_W; i++) begin : gFlag
      always_comb begin
        if (flagHoldSelect_reg[i]) begin
          // Held: source set wins over clear
          engineFlagVector_next[i] = flagSrc[i] | (engineFlagVector_reg[i] & ~flagClear[i]);
        end else if (FLAG_EVENT_MASK[i]) begin
          // Event flag: set on event, drop at next packet
          if (flagSrc[i]) begin
            engineFlagVector_next[i] = 1'b1;
          end else if (packetStart) begin
            engineFlagVector_next[i] = 1'b0;
          end else begin
            engineFlagVector_next[i] = engineFlagVector_reg[i];
          end
        end else begin
          // Level flag: follow the source
          engineFlagVector_next[i] = flagSrc[i];
        end
      end
    end
  endgenerate

  // Flag vector register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engineFlagVector_reg <= '0;
    end else begin
      engineFlagVector_reg <= engineFlagVector_next;
    end
  end

  // Hold select and route masks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagHoldSelect_reg <= REG_RESET[FLAG_W-1:0];
      flagRouteMasks_reg <= REG_RESET;
    end else begin
      if (wrHold) begin
        flagHoldSelect_reg <= regWrData[FLAG_W-1:0];
      end
      if (wrMasks) begin
        // Reserved bits stay zero
        flagRouteMasks_reg <= '0;
        flagRouteMasks_reg[MSK_FIRST_LO +: FLAG_W] <= regWrData[MSK_FIRST_LO +: FLAG_W];
        flagRouteMasks_reg[MSK_SECOND_LO +: FLAG_W] <= regWrData[MSK_SECOND_LO +: FLAG_W];
        flagRouteMasks_reg[MSK_THIRD_LO +: FLAG_W] <= regWrData[MSK_THIRD_LO +: FLAG_W];
      end
    end
  end

  // Flag outputs, one register stage after the flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagOutFirst <= 1'b0;
      flagOutSecond <= 1'b0;
      flagOutThird <= 1'b0;
    end else begin
      // Empty mask, output low
      flagOutFirst <= |(engineFlagVector_reg & flagRouteMasks_reg[MSK_FIRST_LO +: FLAG_W]);
      flagOutSecond <= |(engineFlagVector_reg & flagRouteMasks_reg[MSK_SECOND_LO +: FLAG_W]);
      flagOutThird <= |(engineFlagVector_reg & flagRouteMasks_reg[MSK_THIRD_LO +: FLAG_W]);
    end
  end

  // Frame number: software write wins over a received frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameNumber_reg <= REG_RESET[FRAME_W-1:0];
    end else if (wrFrame) begin
      frameNumber_reg <= regWrData[FRAME_W-1:0];
    end else if (sofValid) begin
      // Link frame number
      frameNumber_reg <= sofFrame;
    end
  end

  // Last packet identifier capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastPacketId_reg <= REG_RESET[NIB_W-1:0];
    end else if (pidValid) begin
      // Valid identifiers only
      lastPacketId_reg <= pidIn;
    end
  end

  // Last endpoint capture and marked delivery
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastEndpoint_reg <= REG_RESET[NIB_W-1:0];
      lastEndpointValid_reg <= 1'b0;
      rxEndpoint <= '0;
      rxEndpointStrobe <= 1'b0;
    end else begin
      // One strobe per delivery
      rxEndpointStrobe <= epValid;
      if (epValid) begin
        lastEndpoint_reg <= epIn;
        lastEndpointValid_reg <= 1'b1;
        // Marked adds bit 4
        if (endpointMarking_reg[epIn]) begin
          rxEndpoint <= {1'b0, epIn} | EP_MARK_OR;
        end else begin
          rxEndpoint <= {1'b0, epIn};
        end
      end
    end
  end

  // Endpoint marking mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      endpointMarking_reg <= REG_RESET[EP_COUNT-1:0];
    end else if (wrMark) begin
      endpointMarking_reg <= regWrData[EP_COUNT-1:0];
    end
  end

  // Power signalling word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      suspendSignalWord_reg <= REG_RESET[PWR_VALID_BIT:0];
    end else if (wrPower) begin
      // Valid bit with data byte
      suspendSignalWord_reg <= regWrData[PWR_VALID_BIT:0];
    end
  end

  // PHY control settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulldownDisable_reg <= 1'b0;
      filterLog2_reg <= '0;
      autoResume_reg <= 1'b0;
      phyConf_reg <= '0;
    end else if (wrPhy) begin
      pulldownDisable_reg <= regWrData[PHY_PULLDOWN_DIS];
      filterLog2_reg <= regWrData[PHY_FILT_LO +: 4];
      autoResume_reg <= regWrData[PHY_AUTO_RESUME];
      phyConf_reg <= regWrData[PHY_CONF_LO +: PHY_CONF_W];
    end
  end

  // Resume cause bits: writing zero clears, a new cause wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      causeSe0_reg <= 1'b0;
      causeK_reg <= 1'b0;
    end else begin
      // Wake-up by reset
      if (lineBus.resumeSe0) begin
        causeSe0_reg <= 1'b1;
      end else if (wrPhy && !regWrData[PHY_CAUSE_SE0]) begin
        causeSe0_reg <= 1'b0;
      end
      // Wake-up by K
      if (lineBus.resumeK) begin
        causeK_reg <= 1'b1;
      end else if (wrPhy && !regWrData[PHY_CAUSE_K]) begin
        causeK_reg <= 1'b0;
      end
    end
  end

  // Resume event towards the suspend controller
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resumeDetected <= 1'b0;
    end else begin
      resumeDetected <= lineBus.resumeSe0 | lineBus.resumeK;
    end
  end

  // PHY control word as read back
  always_comb begin
    phyWord = '0;
    phyWord[PHY_PULLDOWN_DIS] = pulldownDisable_reg;
    phyWord[PHY_CAUSE_SE0] = causeSe0_reg;
    phyWord[PHY_CAUSE_K] = causeK_reg;
    phyWord[PHY_FILT_LO +: 4] = filterLog2_reg;
    phyWord[PHY_AUTO_RESUME] = autoResume_reg;
    phyWord[PHY_CONF_LO +: PHY_CONF_W] = phyConf_reg;
  end

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rdMux = '0;
    case (regAddr)
      OFS_FLAG_VECTOR: rdMux[FLAG_W-1:0] = engineFlagVector_reg;
      OFS_FLAG_HOLD_SELECT: rdMux[FLAG_W-1:0] = flagHoldSelect_reg;
      OFS_FLAG_ROUTE_MASKS: rdMux = flagRouteMasks_reg;
      OFS_FRAME_NUMBER: rdMux[FRAME_W-1:0] = frameNumber_reg;
      OFS_LAST_PACKET_ID: rdMux[NIB_W-1:0] = lastPacketId_reg;
      OFS_LAST_ENDPOINT: rdMux[EP_VALID_BIT:0] = {lastEndpointValid_reg, lastEndpoint_reg};
      OFS_ENDPOINT_MARKING: rdMux[EP_COUNT-1:0] = endpointMarking_reg;
      OFS_SUSPEND_SIGNAL_WORD: rdMux[PWR_VALID_BIT:0] = suspendSignalWord_reg;
      OFS_PHY_LINE_CONTROL: rdMux = phyWord;
      default: rdMux = '0;
    endcase
  end

  // Registered read answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      // Held until next read
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  // Direct control outputs
  assign pulldownDisable = pulldownDisable_reg;
  assign phyConfigPins = phyConf_reg;
  assign autoResume = autoResume_reg;
  assign lineStateFilt = lineBus.lineFilt;
  assign powerSignalValid = suspendSignalWord_reg[PWR_VALID_BIT];
  assign powerSignalData = suspendSignalWord_reg[PWR_VALID_BIT-1:0];
endmodule : ufs_flag_status
`default_nettype wire

// File: tb/ufs_properties.sv
// Port-level timing checker for the flag and status block
`timescale 1ns/100ps
`default_nettype none
module ufs_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  // Receive side
  input wire logic sofValid,
  input wire logic epValid,
  input wire logic [ufs_pkg::NIB_W-1:0] epIn,
  input wire logic [1:0] lineState,
  input wire logic [4:0] rxEndpoint,
  input wire logic rxEndpointStrobe,
  // Watched outputs
  input wire logic flagOutFirst,
  input wire logic flagOutSecond,
  input wire logic flagOutThird,
  input wire logic pulldownDisable,
  input wire logic [ufs_pkg::PHY_CONF_W-1:0] phyConfigPins,
  input wire logic autoResume,
  input wire logic [1:0] lineStateFilt,
  input wire logic resumeDetected,
  input wire logic powerSignalValid,
  input wire logic [7:0] powerSignalData
);
  import ufs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [22:0] maskReg; // Shadow of the route masks
  logic wrPhy; // Write to line control
  logic wrFrm; // Write to frame number
  // Mirror mask writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maskReg <= 23'h0;
    end else if (regWrEn && regAddr == OFS_FLAG_ROUTE_MASKS) begin
      maskReg <= regWrData[22:0];
    end
  end
  assign wrPhy = regWrEn && regAddr == OFS_PHY_LINE_CONTROL;
  assign wrFrm = regWrEn && regAddr == OFS_FRAME_NUMBER;
  a_first_masked: assert property (maskReg[6:0] == 7'h0 |=> !flagOutFirst)
    else $error("first flag out high with empty mask");
  a_second_masked: assert property (maskReg[14:8] == 7'h0 |=> !flagOutSecond)
    else $error("second flag out high with empty mask");
  a_third_masked: assert property (maskReg[22:16] == 7'h0 |=> !flagOutThird)
    else $error("third flag out high with empty mask");
  a_pulldown_bit: assert property (wrPhy |=> pulldownDisable == $past(regWrData[PHY_PULLDOWN_DIS]))
    else $error("pulldown control not taken");
  a_config_pins: assert property (wrPhy |=> phyConfigPins == $past(regWrData[6:4]))
    else $error("config pins not taken");
  a_auto_select: assert property (wrPhy |=> autoResume == $past(regWrData[PHY_AUTO_RESUME]))
    else $error("auto resume select not taken");
  a_power_word: assert property (regWrEn && regAddr == OFS_SUSPEND_SIGNAL_WORD
    |=> {powerSignalValid, powerSignalData} == $past(regWrData[8:0])) else $error("power word wrong");
  a_endpoint_copy: assert property (epValid |=> rxEndpointStrobe && rxEndpoint[3:0] == $past(epIn))
    else $error("endpoint not delivered");
  a_strobe_cause: assert property (rxEndpointStrobe |-> $past(epValid))
    else $error("endpoint strobe without cause");
  a_filter_settled: assert property ($changed(lineStateFilt) |-> lineStateFilt == $past(lineState))
    else $error("filtered line moved to unsettled value");
  a_resume_auto: assert property (resumeDetected |-> $past(autoResume))
    else $error("resume reported without auto select");
  a_frame_readback: assert property ((wrFrm && !sofValid) ##1 (!wrFrm && !sofValid)
    ##1 (regRdEn && regAddr == OFS_FRAME_NUMBER && !wrFrm && !sofValid)
    |=> regRdData == {21'h0, $past(regWrData[10:0], 3)}) else $error("frame number readback wrong");
  // Main scenarios reached
  c_marked_ep: cover property (rxEndpointStrobe && rxEndpoint[4]);
  c_resume: cover property (resumeDetected);
  c_third: cover property (flagOutThird);
endmodule : ufs_properties
bind ufs_flag_status ufs_properties u_props (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .sofValid(sofValid), .epValid(epValid),
  .epIn(epIn), .lineState(lineState), .rxEndpoint(rxEndpoint), .rxEndpointStrobe(rxEndpointStrobe),
  .flagOutFirst(flagOutFirst), .flagOutSecond(flagOutSecond), .flagOutThird(flagOutThird),
  .pulldownDisable(pulldownDisable), .phyConfigPins(phyConfigPins), .autoResume(autoResume),
  .lineStateFilt(lineStateFilt), .resumeDetected(resumeDetected), .powerSignalValid(powerSignalValid),
  .powerSignalData(powerSignalData));
`default_nettype wire

// File: tb/ufs_phy_model.sv
// Transceiver stand-in driving linestate and receive status
`timescale 1ns/100ps
`default_nettype none
module ufs_phy_model (
  // Clock
  input wire logic clk,
  // Requested line conditions
  input wire logic [1:0] lsWant,
  input wire logic actWant,
  input wire logic errWant,
  // Transceiver outputs
  output logic [1:0] lineState,
  output logic rxActive,
  output logic rxError
);
  // Outputs move at the rising edge; error only shows inside a packet
  always @(posedge clk) begin
    lineState <= lsWant;
    rxActive <= actWant;
    rxError <= errWant & actWant;
  end
endmodule : ufs_phy_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the flag and status block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ufs_pkg::*;
  logic clk, rst_n, regWrEn, regRdEn, regRdValid, rxActive, rxError, tokenOk, crcFail, packetStart;
  logic pidValid, epValid, sofValid, suspended, actWant, errWant, flagOutFirst, flagOutSecond, flagOutThird;
  logic rxEndpointStrobe, pulldownDisable, autoResume, resumeDetected, powerSignalValid;
  logic [1:0] lineState, lineStateFilt, lsWant;
  logic [NIB_W-1:0] pidIn, epIn;
  logic [4:0] rxEndpoint;
  logic [PHY_CONF_W-1:0] phyConfigPins;
  logic [7:0] regAddr, powerSignalData;
  logic [FRAME_W-1:0] sofFrame;
  logic [31:0] regWrData, regRdData, rnd;
  logic [31:0] expQ[$]; // Expected read data, oldest first
  logic [7:0] ofs[7] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38}; // Register offsets
  logic [31:0] msk[7] = '{32'h7f, 32'h7f7f7f, 32'h7ff, 32'h0, 32'h0, 32'hffff, 32'h1ff}; // Writable bits
  int errCount, numChecks, n, resumeCnt;
  ufs_flag_status u_dut (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .lineState(lineState),
    .rxActive(rxActive), .rxError(rxError), .tokenOk(tokenOk), .crcFail(crcFail), .packetStart(packetStart),
    .pidValid(pidValid), .pidIn(pidIn), .epValid(epValid), .epIn(epIn), .sofValid(sofValid), .sofFrame(sofFrame),
    .suspended(suspended), .flagOutFirst(flagOutFirst), .flagOutSecond(flagOutSecond),
    .flagOutThird(flagOutThird), .rxEndpoint(rxEndpoint), .rxEndpointStrobe(rxEndpointStrobe),
    .pulldownDisable(pulldownDisable), .phyConfigPins(phyConfigPins), .lineStateFilt(lineStateFilt),
    .autoResume(autoResume), .resumeDetected(resumeDetected), .powerSignalValid(powerSignalValid),
    .powerSignalData(powerSignalData));
  ufs_phy_model u_phy (.clk(clk), .lsWant(lsWant), .actWant(actWant), .errWant(errWant),
    .lineState(lineState), .rxActive(rxActive), .rxError(rxError));
  // Clock, 100 ns period
  always #50 clk = ~clk;
  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // One comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Register write, one cycle, then idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'b0;
    @(negedge clk);
  endtask : wr
  // Register read, result noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regRdEn = 1'b1;
    regAddr = a;
    expQ.push_back(e);
    @(negedge clk);
    regRdEn = 1'b0;
    @(negedge clk);
  endtask : rd
  // One-cycle pulse on an input
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask : pulse
  // Verdict and end of run
  task automatic tallyAndFinish;
    $display("Checks %0d, mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tallyAndFinish
  // Read monitor takes the oldest note
  always @(negedge clk) begin
    if (regRdValid === 1'b1) check(regRdData, expQ.pop_front());
  end
  // Count one-cycle resume pulses
  always @(posedge clk) begin
    if (resumeDetected === 1'b1) resumeCnt <= resumeCnt + 1;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    $display("BAD at %0t: watchdog expired", $time);
    tallyAndFinish();
  end
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {regWrEn, regRdEn, tokenOk, crcFail, packetStart, pidValid, epValid, sofValid, suspended} = '0;
    {actWant, errWant, regAddr, regWrData, pidIn, epIn, sofFrame} = '0;
    lsWant = LS_J;
    rnd = 32'h656dc534;
    errCount = 0;
    numChecks = 0;
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    // Reset values, read-only and unmapped places
    for (n = 8'h20; n <= 8'h40; n += 4) rd(n[7:0], 32'h0);
    check(32'({pulldownDisable, phyConfigPins, autoResume, powerSignalValid, powerSignalData}), 32'h0);
    // Random write then read back through each register except the flag vector
    foreach (ofs[i]) begin
      rnd = lfsr(rnd);
      wr(ofs[i], rnd);
      rd(ofs[i], rnd & msk[i]);
    end
    check(32'({powerSignalValid, powerSignalData}), {23'h0, rnd[8:0]});
    rnd = lfsr(rnd);
    wr(OFS_PHY_LINE_CONTROL, rnd);
    rd(OFS_PHY_LINE_CONTROL, rnd & 32'h40ff0);
    check(32'({pulldownDisable, phyConfigPins, autoResume}), 32'({rnd[18], rnd[6:4], rnd[7]}));
    foreach (ofs[i]) wr(ofs[i], 32'h0);
    wr(OFS_PHY_LINE_CONTROL, 32'h0);
    // Frame number from the link
    sofFrame = rnd[10:0];
    pulse(sofValid);
    rd(OFS_FRAME_NUMBER, {21'h0, rnd[10:0]});
    // Packet identifier and endpoint, marked then unmarked
    pidIn = rnd[3:0];
    pulse(pidValid);
    rd(OFS_LAST_PACKET_ID, {28'h0, rnd[3:0]});
    for (n = 0; n < 2; n++) begin
      wr(OFS_ENDPOINT_MARKING, 32'h1 << rnd[7:4]);
      epIn = rnd[7:4] ^ n[3:0];
      epValid = 1'b1;
      @(negedge clk);
      epValid = 1'b0;
      check(32'({rxEndpointStrobe, rxEndpoint}), 32'({1'b1, n == 0, epIn}));
      @(negedge clk);
      rd(OFS_LAST_ENDPOINT, {27'h0, 1'b1, epIn});
    end
    // Event flag, cleared by next packet unless held
    wr(OFS_FLAG_ROUTE_MASKS, 32'h00400204);
    pulse(crcFail);
    check(32'(flagOutFirst), 32'h1);
    pulse(packetStart);
    check(32'(flagOutFirst), 32'h0);
    wr(OFS_FLAG_HOLD_SELECT, 32'h4);
    pulse(crcFail);
    pulse(packetStart);
    check(32'(flagOutFirst), 32'h1);
    wr(OFS_FLAG_VECTOR, 32'h4);
    check(32'(flagOutFirst), 32'h0);
    wr(OFS_FLAG_HOLD_SELECT, 32'h0);
    // Level flags follow their sources, then the token event flag
    {actWant, errWant} = 2'b11;
    repeat (4) @(negedge clk);
    check(32'(flagOutSecond), 32'h1);
    rd(OFS_FLAG_VECTOR, 32'h0b);
    {actWant, errWant} = 2'b00;
    repeat (4) @(negedge clk);
    check(32'(flagOutSecond), 32'h0);
    pulse(tokenOk);
    check(32'(flagOutThird), 32'h1);
    // Linestate filter of eight clocks, glitch then real change
    wr(OFS_PHY_LINE_CONTROL, 32'h300);
    lsWant = LS_K;
    repeat (3) @(negedge clk);
    lsWant = LS_J;
    repeat (12) @(negedge clk);
    check(32'(lineStateFilt), 32'(LS_J));
    lsWant = LS_K;
    for (n = 0; n < 40 && lineStateFilt !== LS_K; n++) @(negedge clk);
    check(32'(n >= 8 && n <= 12), 32'h1);
    // Automatic resume causes while suspended
    wr(OFS_PHY_LINE_CONTROL, 32'h80);
    lsWant = LS_J;
    suspended = 1'b1;
    repeat (6) @(negedge clk);
    n = resumeCnt;
    lsWant = LS_K;
    repeat (6) @(negedge clk);
    rd(OFS_PHY_LINE_CONTROL, 32'h1080);
    check(32'(resumeCnt - n), 32'h1);
    wr(OFS_PHY_LINE_CONTROL, 32'h80);
    rd(OFS_PHY_LINE_CONTROL, 32'h80);
    lsWant = LS_SE0;
    repeat (6) @(negedge clk);
    rd(OFS_PHY_LINE_CONTROL, 32'h2080);
    wr(OFS_PHY_LINE_CONTROL, 32'h0);
    lsWant = LS_K;
    repeat (6) @(negedge clk);
    rd(OFS_PHY_LINE_CONTROL, 32'h0);
    tallyAndFinish();
  end
endmodule : tb
`default_nettype wire
